// *** deac_defines.vh ***
// constants for the data eeprom access controller
`ifndef DEAC_DEFINES_VH
`define DEAC_DEFINES_VH

// register byte offsets
`define DEAC_OFF_CTRL      8'h00
`define DEAC_OFF_KEY       8'h04
`define DEAC_OFF_ADDR_LO   8'h08
`define DEAC_OFF_ADDR_HI   8'h0C
`define DEAC_OFF_DATA_LO   8'h10
`define DEAC_OFF_DATA_HI   8'h14
`define DEAC_OFF_INT_STAT  8'h18
`define DEAC_OFF_INT_MASK  8'h1C

// control register fields
`define DEAC_CTRL_RD       0
`define DEAC_CTRL_WR       1
`define DEAC_CTRL_WRITE_ENABLE_GATE     2
`define DEAC_CTRL_WRERR    3
`define DEAC_CTRL_PGSEL    7

// interrupt status / mask fields
`define DEAC_INT_DONE      0

// unlock keys
`define DEAC_KEY_FIRST     8'h55
`define DEAC_KEY_SECOND    8'hAA

// reset values
`define DEAC_CTRL_RST      8'h00
`define DEAC_BYTE_RST      8'h00

// write cycle time
`define DEAC_WRITE_TIME_US 5
`define DEAC_CLK_MHZ       25
`define DEAC_WRITE_CYCLES  (`DEAC_WRITE_TIME_US * `DEAC_CLK_MHZ)

// axi response codes
`define DEAC_RESP_OKAY     2'b00
`define DEAC_RESP_SLVERR   2'b10

`endif

// *** deac_ctrl.v ***
// data eeprom access controller with axi4-lite register slave
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "deac_defines.vh"
// Notes on behaviour
// - read: address loaded, select cleared, read strobe set; data ready next cycle.
// - data register holds last read until another read or software write.
// - write starts only after keys 55h then AAh, then write strobe.
// - write strobe cannot be set unless write enable gate already set.
// - hardware never clears the write enable gate.
// - clearing the gate during a write does not disturb it.
// - on write finish, write strobe clears and done flag sets.
// - done flag sticks until software clears; may raise an interrupt.
// - hardware never clears the done flag.
module deac_ctrl #(
    parameter ADDR_W       = 8,
    parameter WRITE_CYCLES = `DEAC_WRITE_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [11:0] mem_addr,
    output reg  [7:0]  mem_wdata,
    output reg         mem_we,
    input  wire [7:0]  mem_rdata,
    output wire        irq
);

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    localparam KS_IDLE = 3'b001;
    localparam KS_K1   = 3'b010;
    localparam KS_K2   = 3'b100;

    reg  [7:0]  mem_q [0:(1<<ADDR_W)-1];
    reg  [7:0]  addr_lo_q;
    reg  [3:0]  addr_hi_q;
    reg  [7:0]  data_lo_q;
    reg  [5:0]  data_hi_q;
    reg         rd_q;
    reg         wr_q;
    reg         write_enable_gate_q;
    reg         wrerr_q;
    reg         pgsel_q;
    reg  [2:0]  key_q;
    reg  [15:0] wcnt_q;
    reg         done_q;
    reg         mask_q;
    reg         aw_hold_q;
    reg         w_hold_q;
    reg  [7:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    wire        wr_go;
    wire        wr_fin;
    wire [7:0]  wb;

    // ------------------------------------------------------------
    // register map, byte offsets on the bus
    // ------------------------------------------------------------
    // 0x00 control: bit0 read strobe, bit1 write strobe, bit2 write
    //      gate, bit3 error flag kept for software, bit7 memory select
    // 0x04 unlock key port: write only, reads back as zero
    // 0x08 address low byte, indexes the byte array
    // 0x0C address high nibble, passed on to mem_addr only
    // 0x10 data low byte, read result or byte to store
    // 0x14 data high bits, plain storage
    // 0x18 interrupt status: bit0 write done, write one to clear
    // 0x1C interrupt mask: bit0 lets write done drive irq
    // unmapped or misaligned offsets answer with a slave error
    // and change no register, though such a write still breaks the unlock sequence

    // ------------------------------------------------------------
    // timing summary
    // ------------------------------------------------------------
    // write: address and data may arrive on separate edges; the
    // register update and bvalid come one edge after both are held,
    // so a same-edge pair answers two edges after the handshake
    // read: rvalid and rdata one edge after the address handshake
    // read strobe: the data byte lands one edge after the control
    // write, so a read of data low after the response sees it
    // write strobe: held for WRITE_CYCLES edges, then mem_we pulses
    // once and the done flag sets on the same edge
    // clk_en low freezes every register, bus side included

    // ------------------------------------------------------------
    // axi write channel capture
    // ------------------------------------------------------------
    // each channel is held until both arrive and the response is gone
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go  = clk_en && aw_hold_q && w_hold_q;
    assign wb     = w_data_q[7:0];
    assign wr_fin = wr_q && (wcnt_q == 16'h0001);

    // a byte write counts only if lane 0 is enabled
    function hit;
        input [7:0] off;
        begin
            hit = wr_go && (aw_addr_q == off) && w_strb_q[0];
        end
    endfunction

    // only aligned offsets up to the mask register answer okay
    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `DEAC_OFF_INT_MASK);
        end
    endfunction

    // each channel is captured on its own handshake; the pair then
    // commits in one cycle, which keeps the register update single
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h00000000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DEAC_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_q) ? `DEAC_RESP_OKAY : `DEAC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // unlock sequence tracker
    // ------------------------------------------------------------
    // keys in strict order
    // any other register write breaks the sequence, so a stray write
    // between the keys and the strobe leaves the write unstarted
    // a strobe accepted in the second-key state consumes the sequence,
    // so every byte needs a fresh pair of keys
    always @(posedge aclk) begin
        if (!aresetn) begin
            key_q <= KS_IDLE;
        end else if (wr_go) begin
            case (key_q)
                KS_IDLE: key_q <= (hit(`DEAC_OFF_KEY) && wb == `DEAC_KEY_FIRST) ? KS_K1 : KS_IDLE;
                KS_K1:   key_q <= (hit(`DEAC_OFF_KEY) && wb == `DEAC_KEY_SECOND) ? KS_K2 : KS_IDLE;
                KS_K2:   key_q <= (hit(`DEAC_OFF_KEY) && wb == `DEAC_KEY_FIRST) ? KS_K1 : KS_IDLE;
                default: key_q <= KS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // control, address and data registers
    // ------------------------------------------------------------
    // software writes land one edge after both channels are held;
    // the read strobe and the write countdown share this process so
    // the data byte keeps a single driver
    always @(posedge aclk) begin
        if (!aresetn) begin
            addr_lo_q <= `DEAC_BYTE_RST;
            addr_hi_q <= 4'h0;
            data_lo_q <= `DEAC_BYTE_RST;
            data_hi_q <= 6'h00;
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            write_enable_gate_q    <= 1'b0;
            wrerr_q   <= 1'b0;
            pgsel_q   <= 1'b0;
            wcnt_q    <= 16'h0000;
            mem_we    <= 1'b0;
            mem_addr  <= 12'h000;
            mem_wdata <= 8'h00;
        end else if (clk_en) begin
            mem_we <= 1'b0;
            if (hit(`DEAC_OFF_ADDR_LO)) addr_lo_q <= wb;
            if (hit(`DEAC_OFF_ADDR_HI)) addr_hi_q <= wb[3:0];
            // software write to data while preparing
            if (hit(`DEAC_OFF_DATA_LO)) data_lo_q <= wb;
            if (hit(`DEAC_OFF_DATA_HI)) data_hi_q <= wb[5:0];
            if (hit(`DEAC_OFF_CTRL)) begin
                write_enable_gate_q  <= wb[`DEAC_CTRL_WRITE_ENABLE_GATE];
                pgsel_q <= wb[`DEAC_CTRL_PGSEL];
                wrerr_q <= wb[`DEAC_CTRL_WRERR];
                if (wb[`DEAC_CTRL_RD] && !wb[`DEAC_CTRL_PGSEL] && !wr_q)
                    rd_q <= 1'b1;
                // strobe needs the gate already set
                if (wb[`DEAC_CTRL_WR] && write_enable_gate_q && key_q == KS_K2 && !wr_q) begin
                    wr_q      <= 1'b1;
                    wcnt_q    <= WRITE_CYCLES[15:0];
                    mem_addr  <= {addr_hi_q, addr_lo_q};
                    mem_wdata <= data_lo_q;
                end
            end
            // read strobe self clears after data load
            if (rd_q) begin
                data_lo_q <= mem_q[addr_lo_q[ADDR_W-1:0]];
                rd_q      <= 1'b0;
            end
            if (wr_q && !wr_fin) wcnt_q <= wcnt_q - 16'h0001;
            if (wr_fin) begin
                wr_q   <= 1'b0;
                wcnt_q <= 16'h0000;
                mem_we <= 1'b1;
            end
        end
    end

    // backing array for the byte cells
    // the cell changes one edge after mem_we, well before software can
    // see the done flag and issue a read strobe for it
    always @(posedge aclk) begin
        if (clk_en && mem_we)
            mem_q[mem_addr[ADDR_W-1:0]] <= mem_wdata;
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // the mask only gates the output: the flag still sets while masked,
    // so software may poll it instead of taking the interrupt
    // sticky done flag, write one to clear, set wins
    always @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            mask_q <= 1'b0;
        end else if (clk_en) begin
            if (hit(`DEAC_OFF_INT_MASK)) mask_q <= wb[`DEAC_INT_DONE];
            if (wr_fin)
                done_q <= 1'b1;
            else if (hit(`DEAC_OFF_INT_STAT) && wb[`DEAC_INT_DONE])
                done_q <= 1'b0;
        end
    end

    // level output built from two flops only
    assign irq = done_q & mask_q;

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    // answer registered one edge after the address handshake; arready
    // stays low while an answer waits, so one read at most is open
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `DEAC_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped(s_axi_araddr) ? `DEAC_RESP_OKAY : `DEAC_RESP_SLVERR;
                case (s_axi_araddr)
                    `DEAC_OFF_CTRL:     s_axi_rdata <= {24'h000000, pgsel_q, 3'b000, wrerr_q, write_enable_gate_q, wr_q, rd_q};
                    `DEAC_OFF_ADDR_LO:  s_axi_rdata <= {24'h000000, addr_lo_q};
                    `DEAC_OFF_ADDR_HI:  s_axi_rdata <= {28'h0000000, addr_hi_q};
                    `DEAC_OFF_DATA_LO:  s_axi_rdata <= {24'h000000, data_lo_q};
                    `DEAC_OFF_DATA_HI:  s_axi_rdata <= {26'h0000000, data_hi_q};
                    `DEAC_OFF_INT_STAT: s_axi_rdata <= {31'h00000000, done_q};
                    `DEAC_OFF_INT_MASK: s_axi_rdata <= {31'h00000000, mask_q};
                    default:            s_axi_rdata <= 32'h00000000; // key port reads zero
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// *** deac_ctrl_chk.sv ***
// port assertions for the eeprom access controller
`timescale 1ns/1ps
module deac_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        mem_we,
    input wire        irq
);
    // ----------------
    // single clock domain
    // ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a new write needs three register writes first, so pulses are far apart
    a_we_single: assert property (mem_we |=> !mem_we [*4])
        else $error("write pulse repeated too soon");
    a_irq_kept: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("irq dropped without software write");
    a_irq_cause: assert property ($rose(irq) |-> mem_we || $past(mem_we) || $rose(s_axi_bvalid))
        else $error("irq rose without cause");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule
bind deac_ctrl deac_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .mem_we, .irq);

// *** tb.sv ***
// self-checking bench for the eeprom access controller
`timescale 1ns/1ps
`include "deac_defines.vh"
module tb;
    reg         aclk = 1'h0;
    reg         aresetn = 1'h0;
    reg  [7:0]  s_axi_awaddr = 8'h00;
    reg  [7:0]  s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg         s_axi_awvalid = 1'h0;
    reg         s_axi_wvalid = 1'h0;
    reg         s_axi_bready = 1'h0;
    reg         s_axi_arvalid = 1'h0;
    reg         s_axi_rready = 1'h0;
    reg  [3:0]  s_axi_wstrb = 4'hF;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_we, irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [11:0] mem_addr;
    wire [7:0]  mem_wdata;
    reg  [31:0] rv;
    reg  [11:0] we_addr;
    reg  [7:0]  we_data;
    reg  [1:0]  rr;
    reg         ah, wh, bh, done;
    integer     fails = 0, samples_checked = 0, cyc = 0, we_cnt = 0, i;

    always #20 aclk = ~aclk;

    // cycle ceiling and capture of each committed write
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (mem_we === 1'h1) begin
            we_cnt = we_cnt + 1;
            we_addr = mem_addr;
            we_data = mem_wdata;
        end
        if (cyc == 3000) begin
            fails = fails + 1;
            end_of_test;
        end
    end

    // shorter write time than the default 125 cycles, still long enough for the gate to drop mid-write
    deac_ctrl #(.WRITE_CYCLES(8)) uut (.aclk, .aresetn, .clk_en(1'h1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_addr, .mem_wdata, .mem_we, .mem_rdata(8'h00), .irq);

    task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task end_of_test;
        begin
            $display("checked %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // handshakes sampled mid-cycle, where ready has settled
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            done = 1'h0;
            while (!done) begin
                @(negedge aclk);
                ah = s_axi_awvalid & s_axi_awready;
                wh = s_axi_wvalid & s_axi_wready;
                bh = s_axi_bvalid;
                rr = s_axi_bresp;
                @(posedge aclk);
                if (ah) s_axi_awvalid <= 1'h0;
                if (wh) s_axi_wvalid <= 1'h0;
                if (bh) s_axi_bready <= 1'h0;
                done = bh;
            end
        end
    endtask

    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            done = 1'h0;
            while (!done) begin
                @(negedge aclk);
                ah = s_axi_arvalid & s_axi_arready;
                bh = s_axi_rvalid;
                rv = s_axi_rdata;
                rr = s_axi_rresp;
                @(posedge aclk);
                if (ah) s_axi_arvalid <= 1'h0;
                if (bh) s_axi_rready <= 1'h0;
                done = bh;
            end
        end
    endtask

    task unlock(input [7:0] k1, input [7:0] k2);
        begin
            wr(8'h04, {24'h0, k1});
            wr(8'h04, {24'h0, k2});
            wr(8'h00, 32'h6);
        end
    endtask

    task ck_irq(input e);
        begin
            @(negedge aclk);
            check("irq", {31'h0, irq}, {31'h0, e});
        end
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 8; i = i + 1) begin
            rd(i[5:0] * 8'h04);
            check("reset", rv, 32'h0);
        end
        rd(8'h20);
        check("badrd", {30'h0, rr}, {30'h0, `DEAC_RESP_SLVERR});
        // address and data loaded before any unlock
        wr(8'h08, 32'h3C);
        wr(8'h10, 32'hA5);
        wr(8'h1C, 32'h1);
        unlock(8'h55, 8'hAA);
        rd(8'h00);
        check("gateoff", rv, 32'h4);
        unlock(8'hAA, 8'h55);
        rd(8'h00);
        check("order", rv, 32'h4);
        wr(8'h04, 32'h55);
        wr(8'h08, 32'h3C);
        wr(8'h04, 32'hAA);
        wr(8'h00, 32'h6);
        rd(8'h00);
        check("broken", rv, 32'h4);
        ck_irq(1'h0);
        // gate dropped while the write is still running
        unlock(8'h55, 8'hAA);
        // gate cleared again right after the strobe
        wr(8'h00, 32'h0);
        while (we_cnt == 0) @(posedge aclk);
        check("wecount", we_cnt, 32'h1);
        check("weaddr", {20'h0, we_addr}, 32'h3C);
        check("wedata", {24'h0, we_data}, 32'hA5);
        rd(8'h00);
        check("wrclear", rv, 32'h0);
        rd(8'h18);
        check("done", rv, 32'h1);
        ck_irq(1'h1);
        wr(8'h1C, 32'h0);
        ck_irq(1'h0);
        rd(8'h18);
        check("sticky", rv, 32'h1);
        wr(8'h1C, 32'h1);
        ck_irq(1'h1);
        wr(8'h18, 32'h1);
        ck_irq(1'h0);
        // data register overwritten before the read must be replaced
        wr(8'h10, 32'h11);
        wr(8'h00, 32'h1);
        rd(8'h10);
        check("rddata", rv, 32'hA5);
        rd(8'h00);
        check("rdclear", rv, 32'h0);
        wr(8'h08, 32'h0);
        rd(8'h10);
        check("rdhold", rv, 32'hA5);
        // gate left set across a whole write: hardware must keep it
        wr(8'h08, 32'h3D);
        wr(8'h10, 32'h5A);
        wr(8'h00, 32'h4);
        unlock(8'h55, 8'hAA);
        while (we_cnt == 1) @(posedge aclk);
        rd(8'h00);
        check("gatekept", rv, 32'h4);
        check("weaddr2", {20'h0, we_addr}, 32'h3D);
        wr(8'h00, 32'h1);
        rd(8'h10);
        check("rdnew", rv, 32'h5A);
        // lane 0 disabled: the byte write is dropped
        s_axi_wstrb <= 4'hE;
        wr(8'h08, 32'h77);
        s_axi_wstrb <= 4'hF;
        rd(8'h08);
        check("nostrb", rv, 32'h3D);
        wr(8'h20, 32'h1);
        check("badwr", {30'h0, rr}, {30'h0, `DEAC_RESP_SLVERR});
        end_of_test;
    end
endmodule
